//--- supply_supervisor_reset.sv
// supply supervisor reset: with clk_en high, holds the system reset while supply is low
// and for a release delay after it recovers; open-drain output pin.
// assumes supply_trip_threshold comes from an analog comparator, synchronous to clock
//
// Summary of operation
// - assert reset whenever supply below threshold and clk_en is high
// - release only after 200ms above threshold
// - reset active from power-up until settled
// - power-up release delay nominally 200ms
// - keep reset asserted throughout power-down while clk_en is high
// - open drain output, selectable polarity
`timescale 1ns/1ns
`default_nettype none
module supply_supervisor_reset
  import supply_supervisor_pkg::*;
#(
  parameter int unsigned DELAY_CYCLES = RELEASE_DELAY_CYCLES,
  parameter logic ACTIVE_HIGH = POLARITY_ACTIVE_LOW
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic supply_trip_threshold,
  input wire logic reset_pin_in,
  output logic reset_pin_out,
  output logic reset_pin_oe,
  output logic reset_active
);

  supervisor_state_t state;
  supervisor_state_t next_state;
  logic [DELAY_WIDTH-1:0] delay_count;
  logic delay_done;

  ////////////////////////////////////////////////////////////////////////
  // release delay sequencing

  // last count reached; delay is counted from the first cycle in st_delay, one after the first cycle above trip
  assign delay_done = (delay_count == DELAY_WIDTH'(DELAY_CYCLES - 1));

  always_comb begin
    next_state = state;
    unique case (state)
      st_hold: begin
        // leave hold only once supply above trip
        if (supply_trip_threshold) begin
          next_state = st_delay;
        end
      end
      st_delay: begin
        if (!supply_trip_threshold) begin
          next_state = st_hold;
        end else if (delay_done) begin
          next_state = st_run;
        end
      end
      st_run: begin
        if (!supply_trip_threshold) begin
          next_state = st_hold;
        end
      end
      default: next_state = st_hold;
    endcase
  end

  // state register; system reset stands for power-up
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state <= st_hold;
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      delay_count <= '0;
    end else if (clk_en) begin
      if (state == st_delay && supply_trip_threshold && !delay_done) begin
        delay_count <= delay_count + 1'b1;
      end else begin
        delay_count <= '0; // full restart on any dip
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // open-drain output; reset_pin_in unused, the pin is wired-or

  // reset held in every non-run state
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      reset_active <= RESET_ACTIVE_AT_RESET;
    end else if (clk_en) begin
      reset_active <= (next_state != st_run);
    end
  end

  // drive only the low level
  // active low pulls down when asserted; active high pulls down when idle
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      reset_pin_out <= 1'b0;
      reset_pin_oe <= !ACTIVE_HIGH;
    end else if (clk_en) begin
      reset_pin_out <= 1'b0;
      reset_pin_oe <= ACTIVE_HIGH ? (next_state == st_run)
                                  : (next_state != st_run);
    end
  end

  logic unused_pin;
  assign unused_pin = reset_pin_in;

endmodule
`default_nettype wire

//--- supply_supervisor_pkg.sv
// constants shared by the supply supervisor reset logic
// assumes a single 100 MHz core clock
package supply_supervisor_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  // release delay after supply recovers, nominal
  localparam int unsigned RELEASE_DELAY_MS = 200;
  localparam int unsigned RELEASE_DELAY_CYCLES =
    (RELEASE_DELAY_MS * 1000000) / CLK_PERIOD_NS;
  localparam int unsigned DELAY_WIDTH = 32;
  // output polarity variants
  localparam logic POLARITY_ACTIVE_LOW = 1'b0;
  localparam logic POLARITY_ACTIVE_HIGH = 1'b1;
  // reset asserted after power-up or system reset
  localparam logic RESET_ACTIVE_AT_RESET = 1'b1;
  typedef enum logic [1:0] {
    st_hold = 2'b00,
    st_delay = 2'b01,
    st_run = 2'b10
  } supervisor_state_t;
endpackage

//--- supply_supervisor_sva.sv
// checker for the supervisor ports; active-low variant, delay of 10
`timescale 1ns/1ns
`default_nettype none
module supply_supervisor_sva(
  input wire logic core_clk, sys_rst, clk_en, supply_trip_threshold,
  input wire logic reset_pin_in, reset_pin_out, reset_pin_oe, reset_active);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  property p_low; clk_en && !supply_trip_threshold |=> reset_active;
  endproperty
  a_low: assert property (p_low) else $error("low supply not held");
  property p_hold; $rose(supply_trip_threshold) |-> reset_active[*8];
  endproperty
  a_hold: assert property (p_hold) else $error("early release");
  property p_por; disable iff (1'b0) sys_rst |=> reset_active; endproperty
  a_por: assert property (p_por) else $error("reset not active");
  property p_rel; $fell(reset_active) |-> $past(supply_trip_threshold, 11);
  endproperty
  a_rel: assert property (p_rel) else $error("release too soon");
  // pin is only ever pulled low, never driven high
  property p_pin; reset_pin_oe == reset_active && !reset_pin_out; endproperty
  a_pin: assert property (p_pin) else $error("pin mismatch");
  // release only follows an edge that saw the supply above trip
  property p_up; $fell(reset_active) |-> $past(supply_trip_threshold);
  endproperty
  a_up: assert property (p_up) else $error("release on low supply");
  // clock enable low must freeze the reset state
  property p_frz; !clk_en |=> $stable(reset_active); endproperty
  a_frz: assert property (p_frz) else $error("reset moved while frozen");
  cover property ($fell(reset_active));
  cover property ($rose(reset_active));
  cover property (!clk_en && reset_active);
endmodule
`default_nettype wire

//--- host_reset_model.sv
// host reset input: open-drain line with an external pull-up
`timescale 1ns/1ns
`default_nettype none
module host_reset_model(input wire logic pin_oe, output logic pin_level,
  output logic in_reset);
  assign pin_level = pin_oe ? 1'b0 : 1'b1;
  assign in_reset = !pin_level;
endmodule
`default_nettype wire

//--- supply_supervisor_reset_tb_top.sv
// testbench for the supervisor; delay shortened to 10 cycles
`timescale 1ns/1ns
`default_nettype none
module supply_supervisor_reset_tb_top;
  import supply_supervisor_pkg::*;
  logic core_clk = 0, sys_rst = 1, clk_en = 1, sup = 0;
  logic oe, act, pin, host_rst;
  int failures = 0, samples_checked = 0;
  supply_supervisor_reset #(.DELAY_CYCLES(10)) supply_supervisor_reset_i(
    .core_clk, .sys_rst, .clk_en, .supply_trip_threshold(sup),
    .reset_pin_in(pin), .reset_pin_out(), .reset_pin_oe(oe),
    .reset_active(act));
  host_reset_model host_reset_model_i(.pin_oe(oe), .pin_level(pin),
    .in_reset(host_rst));
  initial forever #5 core_clk = ~core_clk;
  task tick(input int n); repeat (n) @(posedge core_clk); #1; endtask
  task check(input logic seen, input logic exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task give_verdict;
    $display("failures=%0d checks=%0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // reset then a full release delay
  task power_up;
    sys_rst = 1; sup = 0; tick(2); sys_rst = 0;
    check(host_rst, 1'b1);
    sup = 1; tick(10); check(host_rst, 1'b1);
    tick(1); check(host_rst, 1'b0);
  endtask
  // dip mid-delay must restart the whole count
  task brownout;
    sup = 0; tick(1); check(act, 1'b1);
    sup = 1; tick(5); sup = 0; tick(1); sup = 1;
    tick(10); check(host_rst, 1'b1);
    tick(1); check(act, 1'b0);
  endtask
  // clock enable low freezes the output
  task freeze;
    clk_en = 0; sup = 0; tick(3); check(act, 1'b0);
    clk_en = 1; tick(1); check(host_rst, 1'b1);
  endtask
  initial begin
    power_up(); brownout(); freeze(); power_up();
    give_verdict();
  end
endmodule
bind supply_supervisor_reset supply_supervisor_sva supply_supervisor_sva_i(.*);
`default_nettype wire
